// ### tb/rtc_timer_alarm_control_properties.sv
`default_nettype none
module rtc_timer_alarm_control_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // watched ports
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic alarm_irq_clear_i,
    input wire logic slow_osc_enable_o,
    input wire logic missing_clock_detect_enable_o,
    input wire logic alarm_irq_o,
    input wire logic alarm_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // control register accesses
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence ctrl_wr;
        reg_write_i && reg_addr_i == 4'h4;
    endsequence
    sequence ctrl_rd;
        reg_read_i && reg_addr_i == 4'h4;
    endsequence
    // ==========================================
    // properties
    osc_enable_a: assert property (
        ctrl_wr |=> slow_osc_enable_o == $past(reg_wdata_i[7])) else $error("osc enable wrong");
    detect_enable_a: assert property (
        ctrl_wr |=> missing_clock_detect_enable_o == $past(reg_wdata_i[6])) else $error("mcd wrong");
    alarm_clear_a: assert property (
        ctrl_wr ##0 !reg_wdata_i[3] |=> !alarm_flag_o) else $error("flag not cleared");
    flag_read_a: assert property (
        ctrl_rd |=> reg_rdata_o[2] == $past(alarm_flag_o)) else $error("flag readback wrong");
    irq_set_a: assert property (
        $rose(alarm_flag_o) |-> alarm_irq_o) else $error("irq not set");
    irq_hold_a: assert property (
        alarm_irq_o && !alarm_irq_clear_i |=> alarm_irq_o) else $error("irq dropped");
    irq_clear_a: assert property (
        alarm_irq_clear_i |=> !alarm_irq_o || $rose(alarm_flag_o)) else $error("irq not cleared");
    reset_zero_a: assert property (
        $rose(reset_n_i) |-> !slow_osc_enable_o && !alarm_irq_o && !alarm_flag_o)
        else $error("outputs not zero after reset");
endmodule // rtc_timer_alarm_control_properties

bind rtc_timer_alarm_control rtc_timer_alarm_control_properties rtc_timer_alarm_control_properties_i (
    .clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .alarm_irq_clear_i, .slow_osc_enable_o, .missing_clock_detect_enable_o, .alarm_irq_o,
    .alarm_flag_o);
`default_nettype wire

// ### tb/rtc_timer_alarm_control_tb.sv
`default_nettype none
module rtc_timer_alarm_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, reset_n_i = 0, reg_write_i = 0, reg_read_i = 0, slow_clk_i = 0;
    logic missing_clock_timeout_i = 0, alarm_irq_clear_i = 0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, r;
    logic slow_osc_enable_o, missing_clock_detect_enable_o, alarm_irq_o, alarm_flag_o;
    logic [31:0] w;
    int failures = 0, cmp_count = 0;
    // ==========================================
    // clock and device
    always #10 clk_i = ~clk_i;
    rtc_timer_alarm_control rtc_timer_alarm_control_i (.clk_i, .reset_n_i, .reg_addr_i,
        .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .slow_clk_i,
        .missing_clock_timeout_i, .slow_osc_enable_o, .missing_clock_detect_enable_o,
        .alarm_irq_clear_i, .alarm_irq_o, .alarm_flag_o);
    // ==========================================
    // access tasks
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        @(posedge clk_i);
        #1 r = reg_rdata_o;
    endtask
    // multi-byte words go lowest address first, low byte there
    task automatic wr32(input logic [3:0] a, input logic [31:0] v);
        for (int i = 0; i < 4; i++) wr(a + 4'(i), v[8*i +: 8]);
    endtask
    task automatic rd32(input logic [3:0] a);
        for (int i = 0; i < 4; i++) begin
            rd(a + 4'(i));
            w[8*i +: 8] = r;
        end
    endtask
    // slow clock held four fast cycles per level, enough for the 3-flop sync
    task automatic tick(input int n);
        repeat (2 * n) begin
            @(posedge clk_i);
            slow_clk_i <= ~slow_clk_i;
            repeat (3) @(posedge clk_i);
        end
        #1;
    endtask
    task automatic stop_test;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog: the sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        stop_test();
    end
    // ==========================================
    // test sequence
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(4'h4);
        chk("control reset", r, 8'h00);
        rd(4'hd);
        chk("unmapped read", r, 8'h00);
        wr(4'h4, 8'hd0);
        @(posedge clk_i);
        missing_clock_timeout_i <= 1'b1;
        // three sync stages plus the flag edge before the read is issued
        repeat (4) @(posedge clk_i);
        rd(4'h4);
        chk("fail flag set", r, 8'hf0);
        chk("osc enable", slow_osc_enable_o, 1'b1);
        chk("detector enable", missing_clock_detect_enable_o, 1'b1);
        wr(4'h4, 8'h90);
        rd(4'h4);
        chk("fail flag cleared", r, 8'h90);
        chk("detector off", missing_clock_detect_enable_o, 1'b0);
        // load across a byte carry, then snapshot while running
        wr32(4'h0, 32'h1234_56fe);
        wr(4'h4, 8'h92);
        rd(4'h4);
        chk("load pending", r[1], 1'b1);
        tick(4);
        rd(4'h4);
        chk("load done", r[1], 1'b0);
        wr(4'h4, 8'h91);
        tick(1);
        rd32(4'h0);
        chk("running snapshot", w, 32'h1234_5701);
        wr(4'h4, 8'h80);
        tick(2);
        wr(4'h4, 8'h81);
        tick(1);
        rd32(4'h0);
        chk("stopped snapshot", w, 32'h1234_5702);
        // alarm two counts ahead, enable written last
        wr32(4'h8, 32'h1234_5704);
        wr(4'h4, 8'h98);
        tick(1);
        chk("no early alarm", alarm_flag_o, 1'b0);
        tick(1);
        chk("alarm flag", alarm_flag_o, 1'b1);
        chk("alarm irq", alarm_irq_o, 1'b1);
        rd(4'h4);
        chk("flag readback", r[2], 1'b1);
        tick(1);
        chk("flag drop", alarm_flag_o, 1'b0);
        chk("irq held", alarm_irq_o, 1'b1);
        @(posedge clk_i);
        alarm_irq_clear_i <= 1'b1;
        tick(1);
        chk("irq cleared", alarm_irq_o, 1'b0);
        @(posedge clk_i);
        alarm_irq_clear_i <= 1'b0;
        // interval mode: match 2, counter loaded with 0
        wr(4'h4, 8'h90);
        wr32(4'h8, 32'h0000_0002);
        wr32(4'h0, 32'h0000_0000);
        wr(4'h4, 8'h9e);
        tick(3);
        chk("interval alarm", alarm_flag_o, 1'b1);
        tick(1);
        wr(4'h4, 8'h9d);
        tick(1);
        rd32(4'h0);
        chk("counter cleared", w, 32'h0000_0000);
        tick(1);
        chk("second alarm", alarm_flag_o, 1'b1);
        wr(4'h4, 8'h94);
        rd(4'h4);
        chk("disable clears flag", r[2], 1'b0);
        // perpetual use: free wrap, match advanced by 32-bit addition
        wr(4'h4, 8'h90);
        wr32(4'h0, 32'hffff_fffe);
        wr(4'h4, 8'h92);
        wr32(4'h8, 32'hffff_ffff);
        tick(2);
        chk("disabled compare", alarm_flag_o, 1'b0);
        wr32(4'h8, 32'hffff_ffff + 32'h0000_0002);
        wr(4'h4, 8'h98);
        tick(2);
        chk("alarm after wrap", alarm_flag_o, 1'b1);
        // re-enable with unchanged match must not fire on the next tick
        wr(4'h4, 8'h90);
        wr(4'h4, 8'h98);
        tick(1);
        chk("no repeat alarm", alarm_flag_o, 1'b0);
        stop_test();
    end
endmodule // rtc_timer_alarm_control_tb
`default_nettype wire

// ### verilog/rtc_timer_alarm_control.v
// Operation
// - writing zero to alarm enable clears the alarm event flag.
// - re-enabling after an alarm with unchanged match waits a full 2^32 wrap.
// - alarm event flag lasts at most one slow oscillator cycle.
// - each alarm event is latched into a persistent interrupt request.
// - with auto-reset, hardware zeroes counter at the tick after an alarm if run is set, no load is pending and the alarm is still enabled.
// - control bit 7 enables the slow oscillator.
// - control bit 6 enables the missing-clock detector.
// - control bit 5 set on detector timeout, held until software clears it.
// - control bit 4 runs the counter; zero holds its value.
// - control bit 3 enables the alarm compare.
// - bit 2 reads alarm flag, writes store auto-reset enable.
// - writing 1 to bit 1 loads snapshot into counter; cleared when done.
// - writing 1 to bit 0 copies counter to snapshot; cleared when done.
// - counter increments once per slow oscillator cycle while running.
// - alarm raised when counter exactly equals the match value.
// - auto-reset clears counter one slow cycle after the alarm.
// - load and snapshot work without stopping; software orders its accesses.
`include "rtc_timer_alarm_defines.vh"
`default_nettype none

module rtc_timer_alarm_control #(
    parameter WIDTH = 32
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // internal register port
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_write_i,
    input wire reg_read_i,
    output reg [7:0] reg_rdata_o,
    // slow oscillator and missing-clock detector
    input wire slow_clk_i,
    input wire missing_clock_timeout_i,
    output wire slow_osc_enable_o,
    output wire missing_clock_detect_enable_o,
    // alarm
    input wire alarm_irq_clear_i,
    output reg alarm_irq_o,
    output reg alarm_flag_o
);

    // =================================================================
    // state
    reg [7:0] rtc_control;
    reg [WIDTH-1:0] counter;
    reg [WIDTH-1:0] snapshot_bytes;
    reg [WIDTH-1:0] alarm_match_bytes;
    reg autoreset_due;
    reg [2:0] slow_sync;
    reg [2:0] fail_sync;
    reg slow_level;
    reg fail_level;

    wire [WIDTH-1:0] next_count;
    wire slow_tick;
    wire fail_event;
    wire ctl_write;

    // byte lane merge for the 32-bit word registers
    function [WIDTH-1:0] put_byte;
        input [WIDTH-1:0] word;
        input [1:0] lane;
        input [7:0] data;
        begin
            put_byte = word;
            put_byte[lane*8 +: 8] = data;
        end
    endfunction

    // =================================================================
    // pin synchronisers: a change counts once stages 2 and 3 agree
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slow_sync <= 3'h0;
            fail_sync <= 3'h0;
            slow_level <= 1'b0;
            fail_level <= 1'b0;
        end else begin
            slow_sync <= {slow_sync[1:0], slow_clk_i};
            fail_sync <= {fail_sync[1:0], missing_clock_timeout_i};
            if (slow_sync[1] == slow_sync[2])
                slow_level <= slow_sync[2];
            if (fail_sync[1] == fail_sync[2])
                fail_level <= fail_sync[2];
        end
    end

    // one tick per slow cycle, only while the oscillator is enabled
    assign slow_tick = slow_sync[1] & slow_sync[2] & ~slow_level
                       & rtc_control[`RTC_BIT_OSC_EN];
    // detector only reports while it and the oscillator are on
    assign fail_event = fail_sync[1] & fail_sync[2] & ~fail_level
                        & rtc_control[`RTC_BIT_MCD_EN]
                        & rtc_control[`RTC_BIT_OSC_EN];
    assign slow_osc_enable_o = rtc_control[`RTC_BIT_OSC_EN];
    assign missing_clock_detect_enable_o = rtc_control[`RTC_BIT_MCD_EN];
    assign ctl_write = reg_write_i && (reg_addr_i == `RTC_ADDR_CONTROL);

    // plain 32-bit wrap; auto-reset replaces the increment
    assign next_count = autoreset_due ? `RTC_WORD_RESET : counter + 1'b1;

    // =================================================================
    // control register; hardware-cleared bits only ever cleared on a tick
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rtc_control <= `RTC_CONTROL_RESET;
            rtc_control[`RTC_BIT_FAIL] <= `RTC_FAIL_RESET;
        end else begin
            // completion on the slow tick acts as the acknowledge; skipping it on a
            // same-cycle write would repeat the transfer, a write of 1 below re-arms
            if (slow_tick) begin
                rtc_control[`RTC_BIT_LOAD] <= 1'b0;
                rtc_control[`RTC_BIT_SNAP] <= 1'b0;
            end
            if (ctl_write) begin
                rtc_control[7:6] <= reg_wdata_i[7:6];
                rtc_control[4:2] <= reg_wdata_i[4:2];
                // software may only clear the fail flag
                if (!reg_wdata_i[`RTC_BIT_FAIL])
                    rtc_control[`RTC_BIT_FAIL] <= 1'b0;
                // writing zero cannot abort a pending transfer
                if (reg_wdata_i[`RTC_BIT_LOAD])
                    rtc_control[`RTC_BIT_LOAD] <= 1'b1;
                if (reg_wdata_i[`RTC_BIT_SNAP])
                    rtc_control[`RTC_BIT_SNAP] <= 1'b1;
            end
            // set wins over a simultaneous software clear
            if (fail_event)
                rtc_control[`RTC_BIT_FAIL] <= 1'b1;
        end
    end

    // =================================================================
    // counter, compare and auto-reset, all advanced on the slow tick
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            counter <= `RTC_WORD_RESET;
            alarm_flag_o <= 1'b0;
            autoreset_due <= 1'b0;
        end else begin
            if (slow_tick) begin
                // flag lives for one slow cycle at most
                alarm_flag_o <= 1'b0;
                autoreset_due <= 1'b0;
                if (rtc_control[`RTC_BIT_LOAD]) begin
                    // load runs without stopping the counter
                    counter <= snapshot_bytes;
                end else if (rtc_control[`RTC_BIT_RUN]) begin
                    counter <= next_count;
                    // only a fresh arrival at the match raises it, so re-enable
                    // with unchanged match waits for the full wrap
                    if (rtc_control[`RTC_BIT_ALARM_EN] && next_count == alarm_match_bytes) begin
                        alarm_flag_o <= 1'b1;
                        autoreset_due <= rtc_control[`RTC_BIT_ALARM_AR];
                    end
                end
            end
            // disabling the alarm kills the flag and any pending reset
            if (ctl_write && !reg_wdata_i[`RTC_BIT_ALARM_EN]) begin
                alarm_flag_o <= 1'b0;
                autoreset_due <= 1'b0;
            end
        end
    end

    // =================================================================
    // persistent interrupt request; a new alarm beats the clear
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            alarm_irq_o <= 1'b0;
        else if (slow_tick && rtc_control[`RTC_BIT_RUN] && !rtc_control[`RTC_BIT_LOAD]
                 && rtc_control[`RTC_BIT_ALARM_EN] && next_count == alarm_match_bytes
                 && !(ctl_write && !reg_wdata_i[`RTC_BIT_ALARM_EN]))
            alarm_irq_o <= 1'b1;
        else if (alarm_irq_clear_i)
            alarm_irq_o <= 1'b0;
    end

    // =================================================================
    // snapshot and match byte registers
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            snapshot_bytes <= `RTC_WORD_RESET;
            alarm_match_bytes <= `RTC_WORD_RESET;
        end else begin
            if (reg_write_i && reg_addr_i[3:2] == 2'h0)
                snapshot_bytes <= put_byte(snapshot_bytes, reg_addr_i[1:0], reg_wdata_i);
            else if (slow_tick && rtc_control[`RTC_BIT_SNAP])
                snapshot_bytes <= counter;
            // match stays host-owned; software disables the alarm first
            if (reg_write_i && reg_addr_i[3:2] == 2'h2)
                alarm_match_bytes <= put_byte(alarm_match_bytes, reg_addr_i[1:0],
                                              reg_wdata_i);
        end
    end

    // =================================================================
    // registered read data; unmapped addresses read zero
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_read_i) begin
            case (reg_addr_i)
                `RTC_ADDR_SNAP0: reg_rdata_o <= snapshot_bytes[7:0];
                `RTC_ADDR_SNAP1: reg_rdata_o <= snapshot_bytes[15:8];
                `RTC_ADDR_SNAP2: reg_rdata_o <= snapshot_bytes[23:16];
                `RTC_ADDR_SNAP3: reg_rdata_o <= snapshot_bytes[31:24];
                `RTC_ADDR_CONTROL: reg_rdata_o <= {rtc_control[7:3], alarm_flag_o,
                                                   rtc_control[1:0]};
                `RTC_ADDR_MATCH0: reg_rdata_o <= alarm_match_bytes[7:0];
                `RTC_ADDR_MATCH1: reg_rdata_o <= alarm_match_bytes[15:8];
                `RTC_ADDR_MATCH2: reg_rdata_o <= alarm_match_bytes[23:16];
                `RTC_ADDR_MATCH3: reg_rdata_o <= alarm_match_bytes[31:24];
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule // rtc_timer_alarm_control

`default_nettype wire

// ### verilog/rtc_timer_alarm_defines.vh
`ifndef RTC_TIMER_ALARM_DEFINES_VH
`define RTC_TIMER_ALARM_DEFINES_VH

// =====================================================================
// register offsets on the internal register port
`define RTC_ADDR_SNAP0 4'h0
`define RTC_ADDR_SNAP1 4'h1
`define RTC_ADDR_SNAP2 4'h2
`define RTC_ADDR_SNAP3 4'h3
`define RTC_ADDR_CONTROL 4'h4
`define RTC_ADDR_MATCH0 4'h8
`define RTC_ADDR_MATCH1 4'h9
`define RTC_ADDR_MATCH2 4'ha
`define RTC_ADDR_MATCH3 4'hb

// =====================================================================
// rtc_control bit positions
`define RTC_BIT_OSC_EN 7
`define RTC_BIT_MCD_EN 6
`define RTC_BIT_FAIL 5
`define RTC_BIT_RUN 4
`define RTC_BIT_ALARM_EN 3
`define RTC_BIT_ALARM_AR 2
`define RTC_BIT_LOAD 1
`define RTC_BIT_SNAP 0

// =====================================================================
// reset values
`define RTC_CONTROL_RESET 8'h00
`define RTC_FAIL_RESET 1'b0
`define RTC_WORD_RESET 32'h0000_0000

`endif
